// *** dv/cbt_bus_node.sv ***
// other bus node: holds the line dominant for a commanded number of cycles
`timescale 1ns/100ps
module cbt_bus_node (
  // clock
  input wire        clk,
  // pulse command
  input wire        go,
  input wire [15:0] len,
  // bus line, recessive when released
  output reg        can_rx
);
  reg [15:0] left_reg;
  initial can_rx = 1'b1;
  initial left_reg = 16'h0000;
  always @(posedge clk)
  begin
    if (go)
    begin
      left_reg <= len;
      can_rx   <= 1'b0;
    end
    else if (left_reg > 16'h0001)
      left_reg <= left_reg - 16'h0001;
    else
    begin
      left_reg <= 16'h0000;
      can_rx   <= 1'b1;
    end
  end
endmodule // cbt_bus_node

// *** dv/cbt_top_bench.sv ***
// bench for configuration, bit timing, receive flags and wakeup
`timescale 1ns/100ps
`include "cbt_consts.vh"
module cbt_top_bench;
  reg         clk, srst, wr, rd, hold, sleep, done, go;
  reg  [2:0]  addr;
  reg  [7:0]  wdata, inb, ien;
  reg  [8:0]  outb;
  reg  [15:0] plen, v;
  wire [7:0]  rdata;
  wire        rx, fg, wirq, eirq, rirq, sv, sval, brec;
  integer     mismatches, checks_done, i;
  cbt_bus_node node (.clk(clk), .go(go), .len(plen), .can_rx(rx));
  cbt_top dut (.CORE_CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .PLL_BUS_CLOCK_TICK(1'b1), .CRYSTAL_CLOCK_TICK(1'b1),
    .CAN_RX(rx), .SOFT_RESET_HOLD(hold), .SLEEP_ACTIVE(sleep), .INBOUND_ERROR_COUNT(inb),
    .OUTBOUND_ERROR_COUNT(outb), .RX_MSG_DONE(done), .RECEIVE_IRQ_ENABLES(ien),
    .FG_LOAD(fg), .WAKE_IRQ(wirq), .ERR_IRQ(eirq), .RX_IRQ(rirq),
    .BIT_SAMPLE_VALID(sv), .BIT_SAMPLE_VALUE(sval), .BUS_OFF_RECOVERED(brec));
  always #2 clk = ~clk;
  task summarize;
  begin
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task chkn(input [15:0] g, input [15:0] e);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  task chk8(input [7:0] g, input [7:0] e);
    chkn({8'h00, g}, {8'h00, e});
  endtask
  task chk1(input g, input e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wr8(input [2:0] a, input [7:0] d);
  begin
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask
  task rdchk(input [2:0] a, input [7:0] m, input [7:0] e);
  begin
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk8(rdata & m, e);
  end
  endtask
  task msg;
  begin
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    #1;
  end
  endtask
  task pulse(input [15:0] n);
  begin
    @(posedge clk);
    go <= 1'b1; plen <= n;
    @(posedge clk);
    go <= 1'b0;
    cyc(n + 16);
  end
  endtask
  // spacing of sample points for one configuration
  task t_timing(input [7:0] c1, input [7:0] t0, input [7:0] t1, input [15:0] e);
  begin
    @(posedge clk);
    hold <= 1'b1;
    wr8(`CBT_OFS_CTRL1, c1);
    wr8(`CBT_OFS_TIM0, t0);
    wr8(`CBT_OFS_TIM1, t1);
    hold <= 1'b0;
    for (i = 0; i < 2; i = i + 1)
    begin
      v = 16'h0000;
      @(posedge clk);
      #1 v = 16'h0001;
      while (sv !== 1'b1 && v < 16'h0400)
      begin
        @(posedge clk);
        #1 v = v + 16'h0001;
      end
      if (v == 16'h0400)
      begin
        mismatches = mismatches + 1;
        summarize;
      end
    end
    chkn(v, e);
    chk1(sval, 1'b1);
  end
  endtask
  task t_regs;
  begin
    for (i = 0; i < 5; i = i + 1)
      rdchk(i[2:0], 8'hFF, 8'h00);
    wr8(`CBT_OFS_CTRL1, 8'hFF);
    rdchk(`CBT_OFS_CTRL1, 8'hFF, 8'h00);
    t_timing(8'hFF, 8'h41, 8'h13, 16'h000E);
    rdchk(`CBT_OFS_CTRL1, 8'hFF, `CBT_CTRL1_MASK);
    rdchk(`CBT_OFS_TIM0, 8'hFF, 8'h41);
    wr8(`CBT_OFS_TIM1, 8'h00);
    rdchk(`CBT_OFS_TIM1, 8'hFF, 8'h13);
    t_timing(8'h04, 8'h01, 8'h13, 16'h001C);
    t_timing(8'h05, 8'h3F, 8'h93, 16'h01C0);
    t_timing(8'h05, 8'h00, 8'h13, 16'h0007);
  end
  endtask
  task t_rx;
  begin
    msg;
    chk1(fg, 1'b1);
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h01);
    chk1(rirq, 1'b1);
    msg;
    chk1(fg, 1'b0);
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h03);
    chk1(eirq, 1'b1);
    wr8(`CBT_OFS_FLAGS, 8'h00);
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h03);
    wr8(`CBT_OFS_FLAGS, 8'h01);
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h02);
    msg;
    chk1(fg, 1'b1);
    wr8(`CBT_OFS_FLAGS, 8'h03);
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h00);
  end
  endtask
  task t_err;
  begin
    @(posedge clk);
    outb <= 9'h061;
    cyc(3);
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h20);
    @(posedge clk);
    inb <= 8'h61;
    cyc(3);
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h60);
    wr8(`CBT_OFS_FLAGS, 8'h60);
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h60);
    @(posedge clk);
    inb <= 8'h00;
    outb <= 9'h000;
    wr8(`CBT_OFS_FLAGS, 8'h60);
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h00);
    @(posedge clk);
    inb <= 8'h80;
    cyc(3);
    rdchk(`CBT_OFS_FLAGS, 8'h10, 8'h10);
    @(posedge clk);
    inb <= 8'h00;
    wr8(`CBT_OFS_FLAGS, 8'hFF);
    outb <= 9'h100;
    cyc(3);
    rdchk(`CBT_OFS_FLAGS, 8'h04, 8'h04);
    chk1(eirq, 1'b1);
    @(posedge clk);
    outb <= 9'h000;
    wr8(`CBT_OFS_FLAGS, 8'hFF);
    rdchk(`CBT_OFS_FLAGS, 8'h04, 8'h04);
    chk1(brec, 1'b0);
    // idle bus gives one recessive sample every 7 cycles
    for (i = 0; i < 16'h3000 && brec !== 1'b1; i = i + 1)
      cyc(1);
    if (brec !== 1'b1)
    begin
      mismatches = mismatches + 1;
      summarize;
    end
    chk1(i > 16'h2648, 1'b1);
    wr8(`CBT_OFS_FLAGS, 8'h04);
    rdchk(`CBT_OFS_FLAGS, 8'h04, 8'h00);
    @(posedge clk);
    outb <= 9'h100;
    cyc(3);
    outb <= 9'h000;
    hold <= 1'b1;
    cyc(3);
    hold <= 1'b0;
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h00);
    chk1(eirq, 1'b0);
  end
  endtask
  task t_wake;
  begin
    @(posedge clk);
    sleep <= 1'b1;
    pulse(16'd100);
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h00);
    pulse(`CBT_WAKE_FILTER_CYC + 100);
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h80);
    chk1(wirq, 1'b1);
    @(posedge clk);
    hold <= 1'b1;
    wr8(`CBT_OFS_CTRL1, 8'h01);
    hold <= 1'b0;
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h00);
    pulse(16'd4);
    rdchk(`CBT_OFS_FLAGS, 8'hFF, 8'h80);
  end
  endtask
  initial
  begin
    clk = 1'b0; srst = 1'b1; wr = 1'b0; rd = 1'b0; hold = 1'b0; sleep = 1'b0;
    done = 1'b0; go = 1'b0; addr = 3'h0; wdata = 8'h00; inb = 8'h00; ien = 8'hFF;
    outb = 9'h000; plen = 16'h0000; v = 16'h0000; mismatches = 0; checks_done = 0;
    cyc(8);
    srst <= 1'b0;
    t_regs;
    t_rx;
    t_err;
    t_wake;
    summarize;
  end
endmodule // cbt_top_bench

// *** dv/cbt_top_properties.sv ***
// checker for the register port, receive flags and interrupt outputs
`timescale 1ns/100ps
module cbt_top_properties (
  // clock and reset
  input wire       CORE_CLK,
  input wire       SRST,
  // watched ports
  input wire       REG_RD,
  input wire [7:0] REG_RDATA,
  input wire       SOFT_RESET_HOLD,
  input wire [8:0] OUTBOUND_ERROR_COUNT,
  input wire       RX_MSG_DONE,
  input wire [7:0] RECEIVE_IRQ_ENABLES,
  input wire       FG_LOAD,
  input wire       WAKE_IRQ,
  input wire       ERR_IRQ,
  input wire       RX_IRQ
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SRST);
  // message completes, swap made next cycle
  sequence load_seq;
    RX_MSG_DONE && !SOFT_RESET_HOLD ##1 FG_LOAD && RECEIVE_IRQ_ENABLES[0] && !SOFT_RESET_HOLD;
  endsequence
  a_load_has_cause: assert property (FG_LOAD |-> $past(RX_MSG_DONE))
    else $error("swap without a completed message");
  a_load_single: assert property (FG_LOAD |=> !FG_LOAD)
    else $error("swap while foreground still full");
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside the answer cycle");
  a_rx_irq_gate: assert property (RX_IRQ |-> $past(RECEIVE_IRQ_ENABLES[0]))
    else $error("receive irq while masked");
  a_err_irq_gate: assert property (ERR_IRQ |-> $past(|RECEIVE_IRQ_ENABLES[6:1]))
    else $error("error irq while masked");
  a_wake_irq_gate: assert property (WAKE_IRQ |-> $past(RECEIVE_IRQ_ENABLES[7]))
    else $error("wake irq while masked");
  a_soft_hold_quiet: assert property (SOFT_RESET_HOLD[*3] |-> !FG_LOAD && !WAKE_IRQ
    && !ERR_IRQ && !RX_IRQ)
    else $error("activity during soft reset");
  a_rx_irq_follows: assert property (load_seq |=> RX_IRQ)
    else $error("receive irq missing after swap");
  a_bus_off_irq: assert property ((OUTBOUND_ERROR_COUNT > 9'h0FF && RECEIVE_IRQ_ENABLES[2]
    && !SOFT_RESET_HOLD)[*3] |-> ERR_IRQ)
    else $error("bus-off irq missing");
endmodule // cbt_top_properties
bind cbt_top cbt_top_properties u_props (.CORE_CLK(CORE_CLK), .SRST(SRST), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .SOFT_RESET_HOLD(SOFT_RESET_HOLD),
  .OUTBOUND_ERROR_COUNT(OUTBOUND_ERROR_COUNT), .RX_MSG_DONE(RX_MSG_DONE),
  .RECEIVE_IRQ_ENABLES(RECEIVE_IRQ_ENABLES), .FG_LOAD(FG_LOAD), .WAKE_IRQ(WAKE_IRQ),
  .ERR_IRQ(ERR_IRQ), .RX_IRQ(RX_IRQ));

// *** verilog/cbt_bit_timer.v ***
// quantum prescaler, bit segment timing, resync and bus sampling
`timescale 1ns/100ps
module cbt_bit_timer (
  // clock and reset
  input  wire       clk,
  input  wire       srst,
  // controller clock tick and timing setup
  input  wire       ctrl_tick,
  input  wire [5:0] quantum_divider,
  input  wire [1:0] resync_jump_limit,
  input  wire [3:0] segment_one_length,
  input  wire [2:0] segment_two_length,
  input  wire       majority_vote_select,
  // synchronised bus level and sampled bit
  input  wire       rx_level,
  output reg        sample_valid,
  output reg        sample_bit
);
  reg  [5:0] pre_reg;
  reg  [5:0] pos_reg;
  reg  [5:0] ext_reg;
  reg        sampled_reg;
  reg        prev_rx_reg;
  reg  [1:0] hist_reg;
  wire       tq_tick;
  wire [5:0] t1;
  wire [5:0] t2;
  wire [5:0] jw;
  wire [5:0] majority_vote_select_pt;
  wire [5:0] bit_end;
  wire [5:0] remain;
  wire       edge_fall;
  wire       vote;

  // one quantum per divider+1 controller ticks
  assign tq_tick = ctrl_tick && (pre_reg == quantum_divider);
  assign t1 = {2'h0, segment_one_length} + 6'h01;
  assign t2 = {3'h0, segment_two_length} + 6'h01;
  assign jw = {4'h0, resync_jump_limit} + 6'h01;
  assign majority_vote_select_pt = t1 + ext_reg;
  assign bit_end = majority_vote_select_pt + t2;
  assign remain = bit_end - pos_reg;
  assign edge_fall = prev_rx_reg && !rx_level;
  assign vote = (hist_reg[1] & hist_reg[0]) | (hist_reg[1] & rx_level)
              | (hist_reg[0] & rx_level);

  always @(posedge clk)
  begin
    if (srst)
    begin
      pre_reg      <= 6'h00;
      pos_reg      <= 6'h00;
      ext_reg      <= 6'h00;
      sampled_reg  <= 1'b0;
      prev_rx_reg  <= 1'b1;
      hist_reg     <= 2'h3;
      sample_valid <= 1'b0;
      sample_bit   <= 1'b1;
    end
    else
    begin
      sample_valid <= 1'b0;
      if (ctrl_tick)
        pre_reg <= tq_tick ? 6'h00 : pre_reg + 6'h01;
      if (tq_tick)
      begin
        prev_rx_reg <= rx_level;
        hist_reg    <= {hist_reg[0], rx_level};
        if (!sampled_reg && pos_reg == majority_vote_select_pt)
        begin
          sample_valid <= 1'b1;
          sample_bit   <= majority_vote_select ? vote : rx_level;
          sampled_reg  <= 1'b1;
        end
        // late edge lengthens segment one, early edge shortens segment two
        if (edge_fall && !sampled_reg && pos_reg != 6'h00)
        begin
          ext_reg <= (pos_reg < jw) ? pos_reg : jw;
          pos_reg <= pos_reg + 6'h01;
        end
        else if (edge_fall && sampled_reg && remain <= jw)
        begin
          pos_reg     <= 6'h00;
          ext_reg     <= 6'h00;
          sampled_reg <= 1'b0;
        end
        else if (edge_fall && sampled_reg)
          pos_reg <= pos_reg + 6'h01 + jw;
        else if (pos_reg >= bit_end)
        begin
          pos_reg     <= 6'h00;
          ext_reg     <= 6'h00;
          sampled_reg <= 1'b0;
        end
        else
          pos_reg <= pos_reg + 6'h01;
      end
    end
  end
endmodule // cbt_bit_timer

// *** verilog/cbt_consts.vh ***
// constants for the bus timing and receive flag block
`ifndef CBT_CONSTS_VH
`define CBT_CONSTS_VH
`define CBT_OFS_CTRL1       3'h0
`define CBT_OFS_TIM0        3'h1
`define CBT_OFS_TIM1        3'h2
`define CBT_OFS_FLAGS       3'h3
`define CBT_CTRL1_RST       8'h00
`define CBT_TIM0_RST        8'h00
`define CBT_TIM1_RST        8'h00
`define CBT_FLAGS_RST       8'h00
`define CBT_WFS_BIT         2
`define CBT_CKS_BIT         0
`define CBT_CTRL1_MASK      8'h05
`define CBT_SJW_MSB         7
`define CBT_SJW_LSB         6
`define CBT_BRP_MSB         5
`define CBT_BRP_LSB         0
`define CBT_MAJORITY_VOTE_SELECT_BIT        7
`define CBT_TS2_MSB         6
`define CBT_TS2_LSB         4
`define CBT_TS1_MSB         3
`define CBT_TS1_LSB         0
`define CBT_F_WAKE          7
`define CBT_F_RXW           6
`define CBT_F_TXW           5
`define CBT_F_RXP           4
`define CBT_F_TXP           3
`define CBT_F_BOFF          2
`define CBT_F_OVR           1
`define CBT_F_RXF           0
`define CBT_WARN_LIMIT      9'h060
`define CBT_PASSIVE_LIMIT   9'h07F
`define CBT_BUSOFF_LIMIT    9'h0FF
`define CBT_RECESSIVE_RUN   4'hB
`define CBT_RECOVERY_RUNS   8'h80
`define CBT_CLK_MHZ         250
`define CBT_WAKE_FILTER_NS  2000
`define CBT_WAKE_FILTER_CYC ((`CBT_WAKE_FILTER_NS * `CBT_CLK_MHZ + 999) / 1000)
`endif

// *** verilog/cbt_top.v ***
// configuration registers, clock select, wakeup and receive flags
`timescale 1ns/100ps
`include "cbt_consts.vh"

// How it works
// - filter on: wake after long dominant pulse; off: any falling edge wakes
// - clock select 1 takes pll bus clock, 0 takes crystal clock halved
// - control one and both timing registers written only during soft reset
// - resync moves a bit edge by at most jump field plus one quanta
// - quantum clock is controller clock divided by divider field plus one
// - vote select takes three samples with majority, otherwise one sample
// - segment one is field plus one, segment two field plus one quanta
// - bit period is clock period times divider plus one times quanta per bit
// - flags clear by writing one, only once their cause has gone
// - hard and soft reset clear the flags, held while soft reset stays
// - wake flag set on bus activity while asleep, irq if enabled
// - rx warning when rx count above 96 and no passive or bus-off
// - tx warning when tx count above 96 and no passive or bus-off
// - passive flags when counts above 127 (tx count not above 255) and bus-off flag clear
// - bus-off above 255, clearable after 128 runs of 11 recessive bits
// - warning, passive, bus-off, overrun flags hold error irq when enabled
// - overrun flag set on overrun, stays until software clears it
// - full flag set on foreground load, blocks swaps, rx irq if enabled
module cbt_top (
  // clock and reset
  input  wire       CORE_CLK,
  input  wire       SRST,
  // register port
  input  wire [2:0] REG_ADDR,
  input  wire [7:0] REG_WDATA,
  input  wire       REG_WR,
  input  wire       REG_RD,
  output reg  [7:0] REG_RDATA,
  // clock sources, as ticks on the core clock
  input  wire       PLL_BUS_CLOCK_TICK,
  input  wire       CRYSTAL_CLOCK_TICK,
  // bus pin
  input  wire       CAN_RX,
  // state from the rest of the controller
  input  wire       SOFT_RESET_HOLD,
  input  wire       SLEEP_ACTIVE,
  input  wire [7:0] INBOUND_ERROR_COUNT,
  input  wire [8:0] OUTBOUND_ERROR_COUNT,
  input  wire       RX_MSG_DONE,
  input  wire [7:0] RECEIVE_IRQ_ENABLES,
  // results
  output reg        FG_LOAD,
  output reg        WAKE_IRQ,
  output reg        ERR_IRQ,
  output reg        RX_IRQ,
  output wire       BIT_SAMPLE_VALID,
  output wire       BIT_SAMPLE_VALUE,
  output reg        BUS_OFF_RECOVERED
);
  localparam [31:0] WAKE_CYC = `CBT_WAKE_FILTER_CYC;
  localparam [9:0]  WAKE_LIM = WAKE_CYC[9:0];

  reg  [7:0] module_control_one_reg;
  reg  [7:0] bus_timing_zero_reg;
  reg  [7:0] bus_timing_one_reg;
  reg  [7:0] receive_flags_reg;
  wire [7:0] receive_flags_next;
  reg        rx_s1_reg;
  reg        rx_s2_reg;
  reg        rx_s3_reg;
  reg        rx_level_reg;
  reg        rx_prev_reg;
  reg        xtal_half_reg;
  reg        ctrl_tick_reg;
  reg  [9:0] wake_cnt_reg;
  reg  [3:0] run_reg;
  reg  [7:0] occ_reg;
  reg  [7:0] rdata_next;
  wire       wr_cfg;
  wire       flag_reset;
  wire       wake_filter_select;
  wire       can_clock_select;
  wire       wake_evt;
  wire       swap_evt;
  wire       ovr_evt;
  wire [8:0] rec9;
  wire [7:0] set_vec;
  wire [7:0] hold_vec;
  wire [7:0] clr_vec;
  wire [3:0] run_inc;
  wire [7:0] occ_inc;

  assign wake_filter_select = module_control_one_reg[`CBT_WFS_BIT];
  assign can_clock_select   = module_control_one_reg[`CBT_CKS_BIT];
  assign flag_reset = SRST || SOFT_RESET_HOLD;
  assign wr_cfg = REG_WR && SOFT_RESET_HOLD;
  assign rec9 = {1'b0, INBOUND_ERROR_COUNT};

  // configuration registers
  always @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      module_control_one_reg <= `CBT_CTRL1_RST;
      bus_timing_zero_reg    <= `CBT_TIM0_RST;
      bus_timing_one_reg     <= `CBT_TIM1_RST;
    end
    else if (wr_cfg)
    begin
      case (REG_ADDR)
        `CBT_OFS_CTRL1:
          module_control_one_reg <= REG_WDATA & `CBT_CTRL1_MASK;
        `CBT_OFS_TIM0:
          bus_timing_zero_reg <= REG_WDATA;
        `CBT_OFS_TIM1:
          bus_timing_one_reg <= REG_WDATA;
        default:
          module_control_one_reg <= module_control_one_reg;
      endcase
    end
  end

  // pin synchroniser, level changes once stages two and three agree
  always @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      rx_s1_reg    <= 1'b1;
      rx_s2_reg    <= 1'b1;
      rx_s3_reg    <= 1'b1;
      rx_level_reg <= 1'b1;
      rx_prev_reg  <= 1'b1;
    end
    else
    begin
      rx_s1_reg   <= CAN_RX;
      rx_s2_reg   <= rx_s1_reg;
      rx_s3_reg   <= rx_s2_reg;
      rx_prev_reg <= rx_level_reg;
      if (rx_s2_reg == rx_s3_reg)
        rx_level_reg <= rx_s3_reg;
    end
  end

  // controller clock source select
  always @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      xtal_half_reg <= 1'b0;
      ctrl_tick_reg <= 1'b0;
    end
    else
    begin
      if (CRYSTAL_CLOCK_TICK)
        xtal_half_reg <= !xtal_half_reg;
      ctrl_tick_reg <= can_clock_select ? PLL_BUS_CLOCK_TICK
                     : (CRYSTAL_CLOCK_TICK && xtal_half_reg);
    end
  end

  // bit timing and sampling
  cbt_bit_timer u_timer (
    .clk                  (CORE_CLK),
    .srst                 (flag_reset),
    .ctrl_tick            (ctrl_tick_reg),
    .quantum_divider      (bus_timing_zero_reg[`CBT_BRP_MSB:`CBT_BRP_LSB]),
    .resync_jump_limit    (bus_timing_zero_reg[`CBT_SJW_MSB:`CBT_SJW_LSB]),
    .segment_one_length   (bus_timing_one_reg[`CBT_TS1_MSB:`CBT_TS1_LSB]),
    .segment_two_length   (bus_timing_one_reg[`CBT_TS2_MSB:`CBT_TS2_LSB]),
    .majority_vote_select (bus_timing_one_reg[`CBT_MAJORITY_VOTE_SELECT_BIT]),
    .rx_level             (rx_level_reg),
    .sample_valid         (BIT_SAMPLE_VALID),
    .sample_bit           (BIT_SAMPLE_VALUE)
  );

  // dominant pulse length filter for wakeup
  always @(posedge CORE_CLK)
  begin
    if (SRST)
      wake_cnt_reg <= 10'h000;
    else if (!SLEEP_ACTIVE || rx_level_reg)
      wake_cnt_reg <= 10'h000;
    else if (wake_cnt_reg != WAKE_LIM)
      wake_cnt_reg <= wake_cnt_reg + 10'h001;
  end

  assign wake_evt = SLEEP_ACTIVE && (wake_filter_select
                  ? (wake_cnt_reg == WAKE_LIM)
                  : (rx_prev_reg && !rx_level_reg));

  // bus-off recovery: count runs of recessive samples
  assign run_inc = run_reg + 4'h1;
  assign occ_inc = occ_reg + 8'h01;

  always @(posedge CORE_CLK)
  begin
    if (SRST || !receive_flags_reg[`CBT_F_BOFF])
    begin
      run_reg           <= 4'h0;
      occ_reg           <= 8'h00;
      BUS_OFF_RECOVERED <= 1'b0;
    end
    else if (BIT_SAMPLE_VALID)
    begin
      if (!BIT_SAMPLE_VALUE)
        run_reg <= 4'h0;
      else if (run_inc == `CBT_RECESSIVE_RUN)
      begin
        run_reg <= 4'h0;
        if (!BUS_OFF_RECOVERED)
          occ_reg <= occ_inc;
        if (occ_inc == `CBT_RECOVERY_RUNS)
          BUS_OFF_RECOVERED <= 1'b1;
      end
      else
        run_reg <= run_inc;
    end
  end

  // receive buffer exchange and overrun
  assign swap_evt = RX_MSG_DONE && !receive_flags_reg[`CBT_F_RXF];
  assign ovr_evt = RX_MSG_DONE && receive_flags_reg[`CBT_F_RXF];

  always @(posedge CORE_CLK)
  begin
    if (flag_reset)
      FG_LOAD <= 1'b0;
    else
      FG_LOAD <= swap_evt;
  end

  // flag set causes and causes that still block a clear
  assign set_vec[`CBT_F_WAKE] = wake_evt;
  assign set_vec[`CBT_F_RXW] = (rec9 > `CBT_WARN_LIMIT)
    && !receive_flags_reg[`CBT_F_RXP] && !receive_flags_reg[`CBT_F_TXP]
    && !receive_flags_reg[`CBT_F_BOFF];
  assign set_vec[`CBT_F_TXW] = (OUTBOUND_ERROR_COUNT > `CBT_WARN_LIMIT)
    && !receive_flags_reg[`CBT_F_RXP] && !receive_flags_reg[`CBT_F_TXP]
    && !receive_flags_reg[`CBT_F_BOFF];
  assign set_vec[`CBT_F_RXP] = (rec9 > `CBT_PASSIVE_LIMIT)
    && !receive_flags_reg[`CBT_F_BOFF];
  assign set_vec[`CBT_F_TXP] = (OUTBOUND_ERROR_COUNT > `CBT_PASSIVE_LIMIT)
    && (OUTBOUND_ERROR_COUNT <= `CBT_BUSOFF_LIMIT)
    && !receive_flags_reg[`CBT_F_BOFF];
  assign set_vec[`CBT_F_BOFF] = OUTBOUND_ERROR_COUNT > `CBT_BUSOFF_LIMIT;
  assign set_vec[`CBT_F_OVR] = ovr_evt;
  assign set_vec[`CBT_F_RXF] = swap_evt;

  assign hold_vec[`CBT_F_WAKE:`CBT_F_TXP] = set_vec[`CBT_F_WAKE:`CBT_F_TXP];
  assign hold_vec[`CBT_F_BOFF] = set_vec[`CBT_F_BOFF] || !BUS_OFF_RECOVERED;
  assign hold_vec[`CBT_F_OVR] = 1'b0;
  assign hold_vec[`CBT_F_RXF] = 1'b0;

  // write one clears, write zero leaves alone
  assign clr_vec = (REG_WR && REG_ADDR == `CBT_OFS_FLAGS) ? REG_WDATA
                 : `CBT_FLAGS_RST;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_flag
      // a set in the clearing cycle wins
      assign receive_flags_next[i] = set_vec[i]
        || (receive_flags_reg[i] && !(clr_vec[i] && !hold_vec[i]));
    end
  endgenerate

  always @(posedge CORE_CLK)
  begin
    if (flag_reset)
      receive_flags_reg <= `CBT_FLAGS_RST;
    else
      receive_flags_reg <= receive_flags_next;
  end

  // pending interrupt lines, gated by the enables held elsewhere
  always @(posedge CORE_CLK)
  begin
    if (flag_reset)
    begin
      WAKE_IRQ <= 1'b0;
      ERR_IRQ  <= 1'b0;
      RX_IRQ   <= 1'b0;
    end
    else
    begin
      WAKE_IRQ <= receive_flags_reg[`CBT_F_WAKE]
                && RECEIVE_IRQ_ENABLES[`CBT_F_WAKE];
      ERR_IRQ  <= |(receive_flags_reg[`CBT_F_RXW:`CBT_F_OVR]
                & RECEIVE_IRQ_ENABLES[`CBT_F_RXW:`CBT_F_OVR]);
      RX_IRQ   <= receive_flags_reg[`CBT_F_RXF]
                && RECEIVE_IRQ_ENABLES[`CBT_F_RXF];
    end
  end

  // read mux, unmapped addresses read zero
  always @*
  begin
    case (REG_ADDR)
      `CBT_OFS_CTRL1:
        rdata_next = module_control_one_reg;
      `CBT_OFS_TIM0:
        rdata_next = bus_timing_zero_reg;
      `CBT_OFS_TIM1:
        rdata_next = bus_timing_one_reg;
      `CBT_OFS_FLAGS:
        rdata_next = receive_flags_reg;
      default:
        rdata_next = `CBT_FLAGS_RST;
    endcase
  end

  always @(posedge CORE_CLK)
  begin
    if (SRST)
      REG_RDATA <= `CBT_FLAGS_RST;
    else if (REG_RD)
      REG_RDATA <= rdata_next;
    else
      REG_RDATA <= `CBT_FLAGS_RST;
  end
endmodule // cbt_top
